// *** shared/tml_consts.svh ***
// Constants for the test-mode controller: modes, field positions, timing
// Assumes inclusion by bare name from the design files
`ifndef TML_CONSTS_SVH
`define TML_CONSTS_SVH
`define TML_NBITS 35
`define TML_MODE_W 5
`define TML_MODE_ZERO 5'h00
`define TML_MODE_MAX 5'h1f
`define TML_M_HORN 5'h03
`define TML_M_STBY 5'h0c
`define TML_M_HYST 5'h0d
`define TML_M_SIL 5'h0e
`define TML_M_CHAM 5'h0f
`define TML_M_BATT 5'h11
`define TML_M_LOAD 5'h12
`define TML_M_LOCK 5'h13
`define TML_SETTLE_US 1000
`define TML_CLK_MHZ 125
`define TML_PIN_N 9
`define TML_PIN_STEP 0
`define TML_PIN_DATA 1
`define TML_PIN_IO 2
`define TML_PIN_DET 3
`define TML_PIN_STBY 4
`define TML_PIN_HYST 5
`define TML_PIN_SIL 6
`define TML_PIN_CHAM 7
`define TML_PIN_BATT 8
`define TML_F_CHAM 35:31
`define TML_F_SILT 30:27
`define TML_F_HYST 26:24
`define TML_F_STBY 23:19
`define TML_F_BATT 17:16
`define TML_F_EOL 15
`define TML_F_GAS 14
`define TML_F_LOC 13
`define TML_F_SYNC 12
`define TML_F_LBSIL 11
`define TML_F_CHIRP 10
`define TML_F_FLASH 9
`define TML_F_MTO 8:7
`define TML_F_ALARM_MEMORY_ENABLE 6
`define TML_F_STIME 5
`define TML_F_SMART 4
`define TML_F_INALM 3
`define TML_F_SILDIS 2
`define TML_F_TONE 1
`define TML_MV_00 16'h1d4c
`define TML_MV_01 16'h1e78
`define TML_MV_10 16'h1af4
`define TML_MV_11 16'h1c20
`define TML_HRS_00 8'h18
`define TML_HRS_01 8'h30
`define TML_HRS_10 8'h00
`define TML_SEC_SHORT 16'h0050
`define TML_SEC_LONG 16'h021c
`endif

// *** shared/tml_pkg.sv ***
// Types shared by the test-mode controller files
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package tml_pkg;
  typedef enum logic [2:0]
  {
    ST_BOOT = 3'b001,
    ST_IDLE = 3'b010,
    ST_TEST = 3'b100
  } tml_state_t;
  typedef struct packed {
    logic [4:0] chamber_voltage_trim;
    logic [3:0] silence_sensitivity_trim;
    logic [2:0] hysteresis_trim;
    logic [4:0] standby_sensitivity_trim;
    logic [1:0] battery_trip_select;
    logic [15:0] battery_trip_mv;
    logic end_of_life_enable;
    logic gas_alarm_io_enable;
    logic alarm_locate_disable;
    logic horn_sync_enable;
    logic low_battery_silence_enable;
    logic memory_chirp_enable;
    logic memory_flash_enable;
    logic [1:0] memory_timeout_select;
    logic [7:0] memory_timeout_hours;
    logic memory_never_timeout;
    logic alarm_memory_enable;
    logic silence_timer_select;
    logic [15:0] silence_seconds;
    logic smart_silence_enable;
    logic silence_in_alarm_only;
    logic silence_disable;
    logic silence_enabled;
    logic tone_pattern_select;
    logic continuous_tone;
  } tml_cfg_t;
endpackage
`default_nettype wire

// *** shared/tml_if.sv ***
// Carrier between the controller and its link-domain shift register
// Assumes load_en is driven on clk, word and full on the shift clock
`timescale 1ns/1ns
`default_nettype none
interface tml_if;
  logic load_en;
  logic [35:1] word;
  logic full;
  modport main (output load_en, input word, input full);
  modport shift (input load_en, output word, output full);
endinterface
`default_nettype wire

// *** design/tml_shift.sv ***
// Shift register running on the tester shift clock
// Assumes data is stable at the rising edge of shift_clk
`timescale 1ns/1ns
`default_nettype none
`include "tml_consts.svh"
module tml_shift
#(
  parameter int NBITS = `TML_NBITS
)
(
  input wire logic shift_clk,
  input wire logic serial_data_pin,
  tml_if.shift lnk
);
  logic en_m;
  logic en_s;
  logic [5:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge shift_clk)
  begin
    en_m <= lnk.load_en;
    en_s <= en_m;
  end

  ////////////////////////////////////////////////////////////////////////
  // Leaving the mode clears the count, so a partial load never commits
  always_ff @(posedge shift_clk)
  begin
    if (!en_s)
    begin
      cnt_r <= 6'h00;
      lnk.full <= 1'b0;
    end
    else if (cnt_r < 6'(NBITS))
    begin
      lnk.word[cnt_r + 6'h01] <= serial_data_pin; // [RL6] [RL7]
      cnt_r <= cnt_r + 6'h01;
      lnk.full <= (cnt_r == 6'(NBITS - 1));
    end
  end
endmodule
`default_nettype wire

// *** design/tml_top.sv ***
// Test-mode controller: step-pin mode select, verify result, nv commit
// Assumes asynchronous pins and a tester-driven shift clock
// Operation
// RL1 - Bias low on data, interconnect, shift, step, detect high: rest idle; the code does not check shift
// RL2 - Step high enters mode zero; step pulses with data high advance
// RL3 - Mode twelve, data low one millisecond: result shows standby smoke
// RL4 - Modes thirteen to fifteen: data pulse latches comparator onto result
// RL5 - Eighteen step pulses select the combined serial load mode
// RL6 - Load mode samples data pin on shift clock, high means one
// RL7 - Tester shifts feature bits then calibration bits, LSB first
// RL8 - After thirty-five bits an interconnect pulse commits the word
// RL9 - Positions 35-31, 30-27, 26-24, 23-19 hold the four trims
// RL10 - Position 18 ignored; 17:16 pick the battery trip voltage
// RL11 - Positions 15,14,12,11 enable features; position 13 disables locate
// RL12 - Positions 8:7 memory timeout, 6 memory enable, 10,9 chirp, flash
// RL13 - Position 5 set gives 80 seconds, clear nine minutes silence
// RL14 - Position 4 set lets high or remote smoke cancel silence
// RL15 - Position 3 set: button release silences only during local alarm
// RL16 - Position 2 set disables silence, clear enables it
// RL17 - Position 1 set continuous tone, clear temporal pattern
// RL18 - Mode three: data low drives the horn without limit
// RL19 - Mode seventeen: interconnect high starts battery test, LED on
// RL20 - Mode nineteen: interconnect pulse with data high sets lock
// RL21 - Mode nineteen: interconnect pulse with data low clears lock
// RL22 - Lock set refuses any commit of user settings
// RL23 - Trims are five, four, three and five bits wide
// RL24 - Pins pass two flip-flops before counting, shifting or committing; the shift register samples the data pin without them
`timescale 1ns/1ns
`default_nettype none
`include "tml_consts.svh"
module tml_top
#(
  parameter int SETTLE_CYC = `TML_SETTLE_US * `TML_CLK_MHZ,
  parameter int SETTLE_W = 17
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic shift_clk,
  input wire logic mode_step_pin,
  input wire logic serial_data_pin,
  input wire logic interconnect_pin,
  input wire logic detect_pin,
  input wire logic smoke_standby_cmp,
  input wire logic smoke_hyst_cmp,
  input wire logic smoke_silence_cmp,
  input wire logic chamber_cmp,
  input wire logic battery_low_cmp,
  input wire logic [35:1] nv_word_stored,
  input wire logic nv_lock_stored,
  output logic result_output_pin,
  output logic indicator_led_pin,
  output logic horn_drive,
  output logic test_active,
  output logic [4:0] mode_num,
  output logic nv_write,
  output logic [35:1] nv_word,
  output logic nv_lock_write,
  output logic nv_lock_value,
  output logic lock_state,
  output logic commit_refused,
  output var tml_pkg::tml_cfg_t cfg
);
  localparam logic [SETTLE_W-1:0] SETTLE_END = SETTLE_W'(SETTLE_CYC);

  tml_pkg::tml_state_t state_r;
  logic [`TML_PIN_N-1:0] pin_raw;
  logic [`TML_PIN_N-1:0] pin_m;
  logic [`TML_PIN_N-1:0] pin_s;
  logic [`TML_PIN_N-1:0] pin_d;
  logic [SETTLE_W-1:0] settle_r;
  logic batt_on_r;
  logic full_m;
  logic full_s;
  logic step_s;
  logic data_s;
  logic io_s;
  logic step_rise;
  logic data_fall;
  logic io_rise;
  logic io_fall;
  logic bias_ok;
  logic in_test;
  logic verify_mode;
  logic verify_cmp;
  logic load_commit;
  logic lock_prog;

  tml_if lnk ();

  tml_shift u_shift
  (
    .shift_clk(shift_clk),
    .serial_data_pin(serial_data_pin),
    .lnk(lnk)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic rise(input logic now, input logic prev);
    rise = now && !prev;
  endfunction

  function automatic logic [15:0] trip_mv(input logic [1:0] sel);
    unique case (sel)
      2'h0: trip_mv = `TML_MV_00;
      2'h1: trip_mv = `TML_MV_01;
      2'h2: trip_mv = `TML_MV_10;
      2'h3: trip_mv = `TML_MV_11;
    endcase
  endfunction

  // Position 18 is never looked at, whatever the tester shifted there
  function automatic tml_pkg::tml_cfg_t decode(input logic [35:1] w);
    tml_pkg::tml_cfg_t c;
    c = '0;
    c.chamber_voltage_trim = w[`TML_F_CHAM]; // [RL9] [RL23]
    c.silence_sensitivity_trim = w[`TML_F_SILT]; // [RL9] [RL23]
    c.hysteresis_trim = w[`TML_F_HYST]; // [RL9] [RL23]
    c.standby_sensitivity_trim = w[`TML_F_STBY]; // [RL9] [RL23]
    c.battery_trip_select = w[`TML_F_BATT]; // [RL10]
    c.battery_trip_mv = trip_mv(w[`TML_F_BATT]); // [RL10]
    c.end_of_life_enable = w[`TML_F_EOL]; // [RL11]
    c.gas_alarm_io_enable = w[`TML_F_GAS]; // [RL11]
    c.alarm_locate_disable = w[`TML_F_LOC]; // [RL11]
    c.horn_sync_enable = w[`TML_F_SYNC]; // [RL11]
    c.low_battery_silence_enable = w[`TML_F_LBSIL]; // [RL11]
    c.memory_chirp_enable = w[`TML_F_CHIRP]; // [RL12]
    c.memory_flash_enable = w[`TML_F_FLASH]; // [RL12]
    c.memory_timeout_select = w[`TML_F_MTO]; // [RL12]
    unique case (w[`TML_F_MTO])
      2'h0: c.memory_timeout_hours = `TML_HRS_00; // [RL12]
      2'h1: c.memory_timeout_hours = `TML_HRS_01; // [RL12]
      2'h2: c.memory_timeout_hours = `TML_HRS_10; // [RL12]
      2'h3: c.memory_never_timeout = 1'b1; // [RL12]
    endcase
    c.alarm_memory_enable = w[`TML_F_ALARM_MEMORY_ENABLE]; // [RL12]
    c.silence_timer_select = w[`TML_F_STIME]; // [RL13]
    c.silence_seconds = w[`TML_F_STIME] ? `TML_SEC_SHORT : `TML_SEC_LONG; // [RL13]
    c.smart_silence_enable = w[`TML_F_SMART]; // [RL14]
    c.silence_in_alarm_only = w[`TML_F_INALM]; // [RL15]
    c.silence_disable = w[`TML_F_SILDIS]; // [RL16]
    c.silence_enabled = !w[`TML_F_SILDIS]; // [RL16]
    c.tone_pattern_select = w[`TML_F_TONE]; // [RL17]
    c.continuous_tone = w[`TML_F_TONE]; // [RL17]
    decode = c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a glitch caught at a clock edge still reaches logic
  assign pin_raw = {battery_low_cmp, chamber_cmp, smoke_silence_cmp,
                    smoke_hyst_cmp, smoke_standby_cmp, detect_pin,
                    interconnect_pin, serial_data_pin, mode_step_pin};

  genvar gi;
  generate
    for (gi = 0; gi < `TML_PIN_N; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          pin_m[gi] <= 1'b0;
          pin_s[gi] <= 1'b0;
        end
        else if (ce)
        begin
          pin_m[gi] <= pin_raw[gi]; // [RL24]
          pin_s[gi] <= pin_m[gi]; // [RL24]
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (reset)
      pin_d <= '0;
    else if (ce)
      pin_d <= pin_s;
  end

  assign step_s = pin_s[`TML_PIN_STEP];
  assign data_s = pin_s[`TML_PIN_DATA];
  assign io_s = pin_s[`TML_PIN_IO];
  assign step_rise = rise(step_s, pin_d[`TML_PIN_STEP]);
  assign data_fall = rise(pin_d[`TML_PIN_DATA], data_s);
  assign io_rise = rise(io_s, pin_d[`TML_PIN_IO]);
  assign io_fall = rise(pin_d[`TML_PIN_IO], io_s);
  assign bias_ok = !step_s && !data_s && !io_s && pin_s[`TML_PIN_DET];
  assign in_test = (state_r == tml_pkg::ST_TEST);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////
  // Mode selection; the count only moves while data is held high
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= tml_pkg::ST_BOOT;
      mode_num <= `TML_MODE_ZERO;
      test_active <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_r)
        tml_pkg::ST_BOOT:
          if (bias_ok)
            state_r <= tml_pkg::ST_IDLE; // [RL1]
        tml_pkg::ST_IDLE:
          if (step_s)
          begin
            state_r <= tml_pkg::ST_TEST; // [RL2]
            mode_num <= `TML_MODE_ZERO; // [RL2]
            test_active <= 1'b1;
          end
        tml_pkg::ST_TEST:
          if (data_s && step_rise && mode_num != `TML_MODE_MAX)
            mode_num <= mode_num + 5'h01; // [RL2] [RL5]
      endcase
    end
  end

  boot_idle_a: assert property (state_r == tml_pkg::ST_BOOT && ce && bias_ok // [RL1]
    |=> state_r == tml_pkg::ST_IDLE) else $error("boot did not reach idle");
  enter_test_a: assert property (state_r == tml_pkg::ST_IDLE && ce && step_s // [RL2]
    |=> in_test && mode_num == `TML_MODE_ZERO) else $error("bad test entry");
  step_count_a: assert property (in_test && ce && data_s && step_rise // [RL2]
    && mode_num != `TML_MODE_MAX |=> mode_num == $past(mode_num) + 5'h01)
    else $error("step pulse not counted");

  ////////////////////////////////////////////////////////////////////////
  // Standby check waits out the settle time with data held low
  always_ff @(posedge clk)
  begin
    if (reset)
      settle_r <= '0;
    else if (ce)
    begin
      if (!in_test || mode_num != `TML_M_STBY || data_s)
        settle_r <= '0;
      else if (settle_r != SETTLE_END)
        settle_r <= settle_r + 1'b1; // [RL3]
    end
  end

  assign verify_mode = in_test && (mode_num == `TML_M_HYST
    || mode_num == `TML_M_SIL || mode_num == `TML_M_CHAM);

  always_comb
  begin
    verify_cmp = pin_s[`TML_PIN_CHAM];
    if (mode_num == `TML_M_HYST)
      verify_cmp = pin_s[`TML_PIN_HYST];
    else if (mode_num == `TML_M_SIL)
      verify_cmp = pin_s[`TML_PIN_SIL];
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (reset)
      result_output_pin <= 1'b0;
    else if (ce)
    begin
      if (in_test && mode_num == `TML_M_STBY && settle_r == SETTLE_END)
        result_output_pin <= pin_s[`TML_PIN_STBY]; // [RL3]
      else if (verify_mode && data_fall)
        result_output_pin <= verify_cmp; // [RL4]
      else if (batt_on_r)
        result_output_pin <= pin_s[`TML_PIN_BATT]; // [RL19]
    end
  end

  settle_result_a: assert property (in_test && ce && mode_num == `TML_M_STBY // [RL3]
    && settle_r == SETTLE_END && !batt_on_r
    |=> result_output_pin == $past(pin_s[`TML_PIN_STBY]))
    else $error("standby result wrong");
  verify_latch_a: assert property (verify_mode && ce && data_fall // [RL4]
    |=> result_output_pin == $past(verify_cmp))
    else $error("verify result wrong");

  ////////////////////////////////////////////////////////////////////////
  // Horn stays on until reset; nothing in test mode stops it
  always_ff @(posedge clk)
  begin
    if (reset)
      horn_drive <= 1'b0;
    else if (ce && in_test && mode_num == `TML_M_HORN && !data_s)
      horn_drive <= 1'b1; // [RL18]
  end

  sequence horn_held_s;
    horn_drive [*3];
  endsequence
  horn_on_a: assert property (in_test && mode_num == `TML_M_HORN && ce // [RL18]
    && !data_s |=> horn_held_s) else $error("horn not held on");

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      batt_on_r <= 1'b0;
      indicator_led_pin <= 1'b0;
    end
    else if (ce && in_test && mode_num == `TML_M_BATT && io_rise)
    begin
      batt_on_r <= 1'b1; // [RL19]
      indicator_led_pin <= 1'b1; // [RL19]
    end
  end

  batt_led_a: assert property (in_test && mode_num == `TML_M_BATT && ce // [RL19]
    && io_rise |=> indicator_led_pin && batt_on_r)
    else $error("battery test not started");

  ////////////////////////////////////////////////////////////////////////
  // Shift clock is idle at commit time, so the word is stable to sample
  always_ff @(posedge clk)
  begin
    if (reset)
      lnk.load_en <= 1'b0;
    else if (ce)
      lnk.load_en <= in_test && mode_num == `TML_M_LOAD; // [RL5]
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      full_m <= 1'b0;
      full_s <= 1'b0;
    end
    else if (ce)
    begin
      full_m <= lnk.full;
      full_s <= full_m;
    end
  end

  assign load_commit = in_test && mode_num == `TML_M_LOAD && io_fall && full_s;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      nv_write <= 1'b0;
      commit_refused <= 1'b0;
      nv_word <= '0;
      cfg <= '0;
    end
    else if (ce)
    begin
      nv_write <= load_commit && !lock_state; // [RL8] [RL22]
      commit_refused <= load_commit && lock_state; // [RL22]
      if (state_r == tml_pkg::ST_BOOT)
        cfg <= decode(nv_word_stored);
      else if (load_commit && !lock_state)
      begin
        nv_word <= lnk.word; // [RL8]
        cfg <= decode(lnk.word);
      end
    end
  end

  commit_word_a: assert property (load_commit && !lock_state && ce // [RL8]
    |=> nv_write && nv_word == $past(lnk.word))
    else $error("commit lost");
  lock_refuse_a: assert property (load_commit && lock_state && ce // [RL22]
    |=> !nv_write && commit_refused) else $error("locked commit taken");
  trip_decode_a: assert property (nv_write |-> cfg.battery_trip_mv == ( // [RL10]
    nv_word[`TML_F_BATT] == 2'h0 ? `TML_MV_00 : nv_word[`TML_F_BATT] == 2'h1 ? `TML_MV_01
    : nv_word[`TML_F_BATT] == 2'h2 ? `TML_MV_10 : `TML_MV_11)) else $error("trip decode wrong");

  ////////////////////////////////////////////////////////////////////////
  // Lock programming is itself never refused, so a lock can be undone
  assign lock_prog = in_test && mode_num == `TML_M_LOCK && io_fall;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lock_state <= 1'b0;
      nv_lock_write <= 1'b0;
      nv_lock_value <= 1'b0;
    end
    else if (ce)
    begin
      nv_lock_write <= lock_prog;
      if (state_r == tml_pkg::ST_BOOT)
        lock_state <= nv_lock_stored;
      else if (lock_prog)
      begin
        lock_state <= data_s; // [RL20] [RL21]
        nv_lock_value <= data_s; // [RL20] [RL21]
      end
    end
  end

  lock_prog_a: assert property (lock_prog && ce // [RL20] [RL21]
    |=> nv_lock_write && nv_lock_value == $past(data_s) && lock_state == $past(data_s))
    else $error("lock not programmed");
endmodule
`default_nettype wire

// *** tb/tml_tester.sv ***
// Tester model: drives the mode, data, interconnect, detect and shift pins
// Assumes the bench clock; pins other than the shift clock change on its falling edge
`timescale 1ns/1ns
`default_nettype none
module tml_tester
(
  input wire logic clk,
  output logic mode_step_pin,
  output logic serial_data_pin,
  output logic interconnect_pin,
  output logic detect_pin,
  output logic shift_clk
);
  initial
  begin
    mode_step_pin = 1'b0;
    serial_data_pin = 1'b0;
    interconnect_pin = 1'b0;
    detect_pin = 1'b1;
    shift_clk = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One 64 ns shift period, offset so its edges miss the system grid
  task automatic sclk();
    #13 shift_clk = 1'b1;
    #32 shift_clk = 1'b0;
    #19;
  endtask
  // Power-up bias, applied while reset is held
  task automatic bias();
    @(negedge clk);
    mode_step_pin = 1'b0;
    serial_data_pin = 1'b0;
    interconnect_pin = 1'b0;
    detect_pin = 1'b1;
  endtask
  task automatic set_step(input logic v);
    mode_step_pin = v;
    cyc(6);
  endtask
  task automatic set_data(input logic v);
    serial_data_pin = v;
    cyc(6);
  endtask
  task automatic set_io(input logic v);
    interconnect_pin = v;
    cyc(6);
  endtask
  task automatic io_pulse();
    set_io(1'b1);
    set_io(1'b0);
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      set_step(1'b0);
      set_step(1'b1);
    end
  endtask
  task automatic enter(input int n);
    set_step(1'b1);
    set_data(1'b1);
    pulses(n);
  endtask
  // Two edges only prime the enable sync; bits follow, features first
  task automatic shift_word(input logic [35:1] w);
    repeat (2) sclk();
    for (int k = 1; k <= 35; k++)
    begin
      serial_data_pin = w[k];
      sclk();
    end
    // Hold time over: show the inverse rather than a stale level
    serial_data_pin = ~w[35];
    cyc(8);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_test_mode_config_loader.sv ***
// Bench for the test-mode controller: modes, verify outputs, load, lock
// Assumes the tester model; a small nv store is kept here
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_test_mode_config_loader;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic stby_cmp = 1'b0;
  logic [2:0] vcmp = 3'h0;
  logic batt_cmp = 1'b0;
  logic [35:1] nv_mem = 35'h0_0000_0000;
  logic lock_mem = 1'b0;
  logic [35:1] ws [4] = '{35'h2_d2b4_a87d, 35'h5_2d4b_5782, 35'h7_ffff_ffff, 35'h0};
  wire mode_step_pin, serial_data_pin, interconnect_pin, detect_pin, shift_clk;
  logic result_output_pin, indicator_led_pin, horn_drive, test_active, nv_write;
  logic nv_lock_write, nv_lock_value, lock_state, commit_refused;
  logic [4:0] mode_num;
  logic [35:1] nv_word;
  tml_pkg::tml_cfg_t cfg;
  int error_cnt = 0;
  int samples_checked = 0;
  int nw_cnt = 0;
  int cr_cnt = 0;
  int lw_cnt = 0;
  int cyc_cnt = 0;
  tml_top #(.SETTLE_CYC(20)) dut
  (
    .clk(clk), .reset(reset), .ce(ce), .shift_clk(shift_clk),
    .mode_step_pin(mode_step_pin), .serial_data_pin(serial_data_pin),
    .interconnect_pin(interconnect_pin), .detect_pin(detect_pin),
    .smoke_standby_cmp(stby_cmp),
    .smoke_hyst_cmp(vcmp[0]), .smoke_silence_cmp(vcmp[1]), .chamber_cmp(vcmp[2]),
    .battery_low_cmp(batt_cmp), .nv_word_stored(nv_mem), .nv_lock_stored(lock_mem),
    .result_output_pin(result_output_pin), .indicator_led_pin(indicator_led_pin),
    .horn_drive(horn_drive), .test_active(test_active), .mode_num(mode_num),
    .nv_write(nv_write), .nv_word(nv_word), .nv_lock_write(nv_lock_write),
    .nv_lock_value(nv_lock_value), .lock_state(lock_state),
    .commit_refused(commit_refused), .cfg(cfg)
  );
  tml_tester tester
  (
    .clk(clk), .mode_step_pin(mode_step_pin), .serial_data_pin(serial_data_pin),
    .interconnect_pin(interconnect_pin), .detect_pin(detect_pin), .shift_clk(shift_clk)
  );
  initial
  begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  // Nv store and pulse counters; the ceiling is about eight runs long
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (nv_write === 1'b1) nw_cnt++;
    if (commit_refused === 1'b1) cr_cnt++;
    if (nv_lock_write === 1'b1) lw_cnt++;
    if (nv_write === 1'b1) nv_mem <= nv_word;
    if (nv_lock_write === 1'b1) lock_mem <= nv_lock_value;
    if (cyc_cnt == 40000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic rst();
    @(negedge clk);
    reset = 1'b1;
    tester.bias();
    repeat (15) @(negedge clk);
    `CHK({test_active, mode_num, horn_drive, nv_write}, 8'h00);
    `CHK(cfg, '0);
    reset = 1'b0;
    // Link count clears on these edges, since loading is off after reset
    repeat (3) tester.sclk();
    `CHK(test_active, 1'b0);
  endtask
  // Expected settings worked out field by field from the word passed in
  task automatic chk_cfg(input logic [35:1] w);
    tml_pkg::tml_cfg_t c;
    logic [15:0] mv [4];
    logic [7:0] hr [4];
    c = cfg;
    mv = '{16'h1d4c, 16'h1e78, 16'h1af4, 16'h1c20};
    hr = '{8'h18, 8'h30, 8'h00, 8'h00};
    `CHK({c.chamber_voltage_trim, c.silence_sensitivity_trim}, w[35:27]);
    `CHK({c.hysteresis_trim, c.standby_sensitivity_trim}, w[26:19]);
    `CHK({c.battery_trip_select, c.battery_trip_mv}, {w[17:16], mv[w[17:16]]});
    `CHK({c.end_of_life_enable, c.gas_alarm_io_enable}, w[15:14]);
    `CHK({c.alarm_locate_disable, c.horn_sync_enable}, w[13:12]);
    `CHK(c.low_battery_silence_enable, w[11]);
    `CHK({c.memory_chirp_enable, c.memory_flash_enable}, w[10:9]);
    `CHK({c.memory_timeout_select, c.memory_never_timeout}, {w[8:7], &w[8:7]});
    if (w[8:7] != 2'h3) `CHK(c.memory_timeout_hours, hr[w[8:7]]);
    `CHK(c.alarm_memory_enable, w[6]);
    `CHK(c.silence_timer_select, w[5]);
    `CHK(c.silence_seconds, w[5] ? 16'h0050 : 16'h021c);
    `CHK(c.smart_silence_enable, w[4]);
    `CHK(c.silence_in_alarm_only, w[3]);
    `CHK({c.silence_disable, c.silence_enabled}, {w[2], ~w[2]});
    `CHK({c.tone_pattern_select, c.continuous_tone}, {w[1], w[1]});
  endtask
  task automatic t_horn();
    rst();
    tester.enter(0);
    `CHK({test_active, mode_num}, 6'h20);
    // Clock enable low: a whole step pulse must go unseen
    ce = 1'b0;
    tester.pulses(1);
    ce = 1'b1;
    tester.cyc(4);
    `CHK(mode_num, 5'h00);
    tester.pulses(3);
    `CHK({mode_num, horn_drive}, 6'h06);
    tester.set_data(1'b0);
    `CHK(horn_drive, 1'b1);
    tester.pulses(1);
    `CHK({mode_num, horn_drive}, 6'h07);
    $display("test horn done");
  endtask
  task automatic t_stby();
    rst();
    tester.enter(12);
    stby_cmp = 1'b1;
    tester.set_data(1'b0);
    `CHK(result_output_pin, 1'b0);
    tester.cyc(24);
    `CHK(result_output_pin, 1'b1);
    stby_cmp = 1'b0;
    tester.cyc(5);
    `CHK(result_output_pin, 1'b0);
    $display("test standby done");
  endtask
  task automatic t_verify(input int m);
    rst();
    tester.enter(m);
    vcmp = 3'h1 << (m - 13);
    tester.cyc(5);
    `CHK(result_output_pin, 1'b0);
    tester.set_data(1'b0);
    `CHK(result_output_pin, 1'b1);
    vcmp = 3'h0;
    tester.set_data(1'b1);
    tester.set_data(1'b0);
    `CHK(result_output_pin, 1'b0);
    $display("test verify %0d done", m);
  endtask
  task automatic t_batt();
    rst();
    tester.enter(17);
    batt_cmp = 1'b1;
    tester.cyc(5);
    `CHK({indicator_led_pin, result_output_pin}, 2'h0);
    tester.set_io(1'b1);
    `CHK({indicator_led_pin, result_output_pin}, 2'h3);
    batt_cmp = 1'b0;
    tester.cyc(5);
    `CHK({indicator_led_pin, result_output_pin}, 2'h2);
    $display("test battery done");
  endtask
  task automatic t_load(input logic [35:1] w);
    int c0;
    rst();
    tester.enter(18);
    `CHK(mode_num, 5'h12);
    c0 = nw_cnt;
    tester.shift_word(w);
    tester.io_pulse();
    `CHK(nw_cnt, c0 + 1);
    `CHK(nv_word, w);
    chk_cfg(w);
    $display("test load done");
  endtask
  task automatic t_lock();
    int c0;
    int c1;
    rst();
    tester.enter(19);
    c0 = lw_cnt;
    tester.io_pulse();
    `CHK(lw_cnt, c0 + 1);
    `CHK({nv_lock_value, lock_state}, 2'h3);
    rst();
    tester.enter(18);
    c0 = nw_cnt;
    c1 = cr_cnt;
    tester.shift_word(~nv_mem);
    tester.io_pulse();
    `CHK({nw_cnt, cr_cnt}, {c0, c1 + 1});
    chk_cfg(nv_mem);
    rst();
    tester.enter(19);
    tester.set_data(1'b0);
    tester.io_pulse();
    `CHK({nv_lock_value, lock_state}, 2'h0);
    rst();
    `CHK(lock_state, 1'b0);
    chk_cfg(nv_mem);
    $display("test lock done");
  endtask
  initial
  begin
    logic [35:1] w;
    t_horn();
    t_stby();
    for (int m = 13; m <= 15; m++)
      t_verify(m);
    t_batt();
    for (int i = 0; i < 4; i++)
    begin
      w = ws[i];
      w[17:16] = i[1:0];
      w[8:7] = i[1:0];
      t_load(w);
    end
    t_lock();
    give_verdict();
  end
endmodule
`default_nettype wire
